/* src/flash_block_protection.v */
// Flash block access checker with policy registers, debug lock and status flags
`include "flash_protect_defs.vh"
`default_nettype none

module flash_block_protection #(
  parameter ADDR_WIDTH = 18,
  parameter BANKS = 4
) (
  input wire ref_clk_in,
  input wire reset_in,
  input wire por_in,
  input wire access_valid_in,
  input wire [ADDR_WIDTH-1:0] access_addr_in,
  input wire access_fetch_in,
  input wire access_from_debug_in,
  input wire access_is_jtag_scan_in,
  output reg access_grant_out,
  output reg bus_fault_out,
  input wire [1:0] policy_wr_sel_in,
  input wire policy_wr_read_in,
  input wire policy_wr_prog_in,
  input wire [31:0] policy_wr_data_in,
  input wire [31:0] policy_rd_sel_in,
  output reg [31:0] read_enable_policy_out,
  output reg [31:0] program_enable_policy_out,
  input wire [31:0] target_address_reg_in,
  input wire [31:0] flash_data_in,
  input wire flash_control_wr_in,
  input wire [31:0] flash_control_reg_in,
  output reg [3:0] flash_control_busy_out,
  input wire flash_op_done_in,
  output reg flash_op_start_out,
  output reg [1:0] flash_op_kind_out,
  input wire [1:0] interrupt_mask_reg_in,
  input wire masked_status_clear_wr_in,
  input wire [1:0] masked_status_clear_reg_in,
  output reg [1:0] raw_int_status_out,
  output reg [1:0] masked_int_status_out,
  output reg flash_int_out,
  output reg debug_enabled_out,
  output reg [31:0] debug_lock_word_out
);

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam integer COMMIT_CYCLES_RAW = `FP_COMMIT_TIME_NS / `FP_CLK_PERIOD_NS;
  localparam integer COMMIT_CYCLES = (COMMIT_CYCLES_RAW < 1) ? 1 : COMMIT_CYCLES_RAW;

  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_FLASH = 3'h2;
  localparam [2:0] ST_COMMIT = 3'h4;

  // ****************************************************************
  // Input synchroniser for the external power-on pin
  // ****************************************************************
  // Power-on restore comes from the supply monitor, outside this clock domain
  reg por_meta;
  reg por_sync;
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      por_meta <= 1'b0;
      por_sync <= 1'b0;
    end else begin
      por_meta <= por_in;
      por_sync <= por_meta;
    end
  end

  // ****************************************************************
  // Policy banks
  // ****************************************************************
  wire [32*BANKS-1:0] read_live;
  wire [32*BANKS-1:0] prog_live;
  wire [32*BANKS-1:0] read_stored;
  wire [32*BANKS-1:0] prog_stored;
  reg [BANKS-1:0] commit_read;
  reg [BANKS-1:0] commit_prog;

  // Bank g holds blocks 32g to 32g+31, so policy bit n guards block n
  genvar g;
  generate
    for (g = 0; g < BANKS; g = g + 1) begin : bank
      policy_bank #(.WIDTH(32)) read_bank (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .por_in(por_sync),
        .wr_in(policy_wr_read_in && (policy_wr_sel_in == g)),
        .wr_data_in(policy_wr_data_in),
        .commit_in(commit_read[g]),
        .live_out(read_live[32*g +: 32]),
        .stored_out(read_stored[32*g +: 32])
      );
      policy_bank #(.WIDTH(32)) prog_bank (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .por_in(por_sync),
        .wr_in(policy_wr_prog_in && (policy_wr_sel_in == g)),
        .wr_data_in(policy_wr_data_in),
        .commit_in(commit_prog[g]),
        .live_out(prog_live[32*g +: 32]),
        .stored_out(prog_stored[32*g +: 32])
      );
    end
  endgenerate

  reg [31:0] next_read_view;
  reg [31:0] next_prog_view;

  // Read-back shows the live copy, so trial clears can be checked before a commit
  always @* begin
    next_read_view = read_live[32*policy_rd_sel_in[1:0] +: 32];
    next_prog_view = prog_live[32*policy_rd_sel_in[1:0] +: 32];
  end

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      read_enable_policy_out <= `FP_POLICY_RESET;
      program_enable_policy_out <= `FP_POLICY_RESET;
    end else begin
      read_enable_policy_out <= next_read_view;
      program_enable_policy_out <= next_prog_view;
    end
  end

  // ****************************************************************
  // Per-block lookup
  // ****************************************************************
  wire [6:0] block_index = access_addr_in[`FP_BLOCK_LSB +: 7];
  wire block_read_ok = read_live[block_index];
  wire [6:0] target_block = target_address_reg_in[`FP_BLOCK_LSB +: 7];
  wire target_prog_ok = prog_live[target_block];

  // ****************************************************************
  // Debug lock word
  // ****************************************************************
  reg [31:0] debug_stored;
  reg [31:0] debug_pending;
  // Only the high-set, low-clear pattern keeps debug on; every other pattern locks it
  wire debug_on = debug_lock_word_out[`FP_DBG_HIGH] & ~debug_lock_word_out[`FP_DBG_LOW];

  // ****************************************************************
  // Access check
  // ****************************************************************
  reg next_grant;
  reg next_fault;

  // Debug-port traffic is judged first so a locked port cannot probe the policies
  always @* begin
    next_grant = 1'b0;
    next_fault = 1'b0;
    if (access_valid_in) begin
      if (access_from_debug_in && !debug_on && !access_is_jtag_scan_in) begin
        next_fault = 1'b1;
      end else if (access_fetch_in) begin
        next_grant = 1'b1;
      end else if (block_read_ok) begin
        next_grant = 1'b1;
      end else begin
        next_fault = 1'b1;
      end
    end
  end

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      access_grant_out <= 1'b0;
      bus_fault_out <= 1'b0;
      debug_enabled_out <= 1'b1;
    end else begin
      debug_enabled_out <= debug_on;
      access_grant_out <= next_grant;
      bus_fault_out <= next_fault;
    end
  end

  // ****************************************************************
  // Commit target decode
  // ****************************************************************
  reg commit_to_debug;
  reg commit_to_policy;
  reg commit_to_prog;
  reg [1:0] commit_bank;

  always @* begin
    commit_to_debug = 1'b0;
    commit_to_policy = 1'b0;
    commit_to_prog = target_address_reg_in[0];
    commit_bank = target_address_reg_in[2:1];
    if (target_address_reg_in == `FP_DBG_TARGET) begin
      commit_to_debug = 1'b1;
    end else if (target_address_reg_in[31:3] == 29'h0) begin
      // Any other target commits nothing rather than guess at a register
      commit_to_policy = 1'b1;
    end
  end

  // ****************************************************************
  // Control sequencer
  // ****************************************************************
  reg [2:0] state;
  reg [7:0] commit_count;
  reg violation_event;
  reg done_event;
  wire key_ok = (flash_control_reg_in[31:16] == `FP_KEY);
  wire [3:0] cmd = flash_control_reg_in[3:0];
  // A wrong key, or a request while busy, is dropped with no status at all
  wire cmd_accepted = flash_control_wr_in && key_ok;

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= ST_IDLE;
      commit_count <= 8'h00;
      flash_control_busy_out <= 4'h0;
      flash_op_start_out <= 1'b0;
      flash_op_kind_out <= 2'h0;
      violation_event <= 1'b0;
      done_event <= 1'b0;
      commit_read <= {BANKS{1'b0}};
      commit_prog <= {BANKS{1'b0}};
      debug_pending <= `FP_DBG_RESET;
    end else begin
      flash_op_start_out <= 1'b0;
      violation_event <= 1'b0;
      done_event <= 1'b0;
      commit_read <= {BANKS{1'b0}};
      commit_prog <= {BANKS{1'b0}};
      case (state)
        ST_IDLE: begin
          if (cmd_accepted) begin
            if (cmd[`FP_CMD_COMMIT]) begin
              state <= ST_COMMIT;
              commit_count <= COMMIT_CYCLES[7:0];
              flash_control_busy_out <= 4'h8;
              if (commit_to_debug) begin
                debug_pending <= debug_pending & flash_data_in;
              end else if (commit_to_policy) begin
                if (commit_to_prog) begin
                  commit_prog[commit_bank] <= 1'b1;
                end else begin
                  commit_read[commit_bank] <= 1'b1;
                end
              end
            end else if (cmd[`FP_CMD_MERASE]) begin
              if (&prog_live) begin
                state <= ST_FLASH;
                flash_op_start_out <= 1'b1;
                flash_op_kind_out <= 2'h2;
                flash_control_busy_out <= 4'h4;
              end else begin
                violation_event <= 1'b1;
              end
            end else if (cmd[`FP_CMD_WRITE] || cmd[`FP_CMD_ERASE]) begin
              if (target_prog_ok) begin
                state <= ST_FLASH;
                flash_op_start_out <= 1'b1;
                flash_op_kind_out <= cmd[`FP_CMD_WRITE] ? 2'h0 : 2'h1;
                flash_control_busy_out <= cmd[`FP_CMD_WRITE] ? 4'h1 : 4'h2;
              end else begin
                violation_event <= 1'b1;
              end
            end
          end
        end
        ST_FLASH: begin
          if (flash_op_done_in) begin
            state <= ST_IDLE;
            flash_control_busy_out <= 4'h0;
            done_event <= 1'b1;
          end
        end
        ST_COMMIT: begin
          if (commit_count <= 8'h01) begin
            state <= ST_IDLE;
            flash_control_busy_out <= 4'h0;
          end else begin
            commit_count <= commit_count - 8'h01;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Debug word storage
  // ****************************************************************
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      debug_stored <= `FP_DBG_RESET;
      debug_lock_word_out <= `FP_DBG_RESET;
    end else begin
      // Folding the pending word in every cycle keeps the stored copy one-way
      // clear-only; only reset_in restores it
      debug_stored <= debug_stored & debug_pending;
      if (por_sync) begin
        debug_lock_word_out <= debug_stored & debug_pending;
      end
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  wire [1:0] events = {done_event, violation_event};
  wire [1:0] clears = masked_status_clear_wr_in ? masked_status_clear_reg_in : 2'h0;
  reg [1:0] next_raw;

  // Set beats clear in one cycle, so an event never slips past a clear
  always @* begin
    next_raw = (raw_int_status_out & ~clears) | events;
  end

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      raw_int_status_out <= 2'h0;
      masked_int_status_out <= 2'h0;
      flash_int_out <= 1'b0;
    end else begin
      raw_int_status_out <= next_raw;
      masked_int_status_out <= next_raw & interrupt_mask_reg_in;
      flash_int_out <= |(next_raw & interrupt_mask_reg_in);
    end
  end

endmodule

`default_nettype wire

/* src/flash_protect_defs.vh */
// Constants for the flash block protection checker
// Operation
// - Two policy bits per 2-KB block, program-enable and read-enable, in four 32-bit pairs.
// - Program-enable one permits program and erase; zero leaves contents unaltered.
// - Read-enable one permits read and execute; zero allows only instruction fetch.
// - Both bits zero: execute-only, data read, program and erase refused.
// - Program one, read zero: program, erase, fetch allowed; data reads refused.
// - Program zero, read one: read-only, reads and fetch allowed, writes refused.
// - Both bits one: unprotected, every access kind accepted.
// - Data read of read-protected block is blocked and signals bus fault.
// - Refused program or erase is suppressed; interrupt only when access mask set.
// - Factory state reads every implemented policy bit as one.
// - Writes to policy registers only clear bits, never set them.
// - Uncommitted cleared bits restore on power-on reset only; here reset_in also sets every bit, committed ones too.
// - Commit through control register makes cleared policy bits permanent.
// - Processor data loads, including literal loads, obey read policy.
// - Debug disabled blocks debug-port access, boundary scan still works.
// - Committed debug disable can never be re-enabled; here reset_in reloads the debug word and re-enables debug.
// - Programming-complete flag sets when a program or erase finishes.
// - Access-violation flag sets on program or erase of protected block.
// - Masks gate flags to interrupt; raw flags always readable.
// - Writing one to masked clear register clears raw and masked flag.
// - Commit starts on key plus commit write; target address selects register; pollable.
// - Committed debug word change takes effect only after next power-on reset.
`ifndef FLASH_PROTECT_DEFS_VH
`define FLASH_PROTECT_DEFS_VH

`define FP_KEY 16'ha442
`define FP_CMD_WRITE 0
`define FP_CMD_ERASE 1
`define FP_CMD_MERASE 2
`define FP_CMD_COMMIT 3
`define FP_POLICY_RESET 32'hffffffff
`define FP_DBG_RESET 32'hfffffffe
`define FP_DBG_TARGET 32'h75100000
`define FP_DBG_LOW 0
`define FP_DBG_HIGH 1
`define FP_INT_ACCESS 0
`define FP_INT_PROG 1
`define FP_BLOCK_LSB 11
`define FP_COMMIT_TIME_NS 100
`define FP_CLK_PERIOD_NS 10

`endif

/* src/policy_bank.v */
// One 32-bit policy register with clear-only writes, commit and power-on restore
`default_nettype none

module policy_bank #(
  parameter WIDTH = 32
) (
  input wire ref_clk_in,
  input wire reset_in,
  input wire por_in,
  input wire wr_in,
  input wire [WIDTH-1:0] wr_data_in,
  input wire commit_in,
  output reg [WIDTH-1:0] live_out,
  output reg [WIDTH-1:0] stored_out
);

  // Stored copy models the nonvolatile cells; a system reset sets both copies to all ones
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      live_out <= {WIDTH{1'b1}};
      stored_out <= {WIDTH{1'b1}};
    end else if (por_in) begin
      live_out <= stored_out;
    end else begin
      if (wr_in) begin
        live_out <= live_out & wr_data_in;
      end
      if (commit_in) begin
        stored_out <= stored_out & live_out;
      end
    end
  end

endmodule

`default_nettype wire

/* bench/flash_block_protection_chk.sv */
// Assertion checker on the flash block protection ports
`default_nettype none
module flash_block_protection_chk (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic por_in,
  input wire logic access_valid_in,
  input wire logic access_fetch_in,
  input wire logic access_from_debug_in,
  input wire logic access_grant_out,
  input wire logic bus_fault_out,
  input wire logic [31:0] policy_rd_sel_in,
  input wire logic [31:0] read_enable_policy_out,
  input wire logic [31:0] program_enable_policy_out,
  input wire logic flash_control_wr_in,
  input wire logic [3:0] flash_control_busy_out,
  input wire logic flash_op_done_in,
  input wire logic masked_status_clear_wr_in,
  input wire logic [1:0] masked_status_clear_reg_in,
  input wire logic [1:0] raw_int_status_out,
  input wire logic [1:0] masked_int_status_out,
  input wire logic [1:0] interrupt_mask_reg_in,
  input wire logic flash_int_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Helper and rules
  // ****************
  // Restore through por_in lags by its synchroniser, so policy growth is only judged well after it
  logic [2:0] quiet;
  always_ff @(posedge ref_clk_in or posedge reset_in)
    if (reset_in) quiet <= 3'h0;
    else if (por_in) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  property p_fetch_grant;
    access_valid_in && access_fetch_in && !access_from_debug_in |=> access_grant_out && !bus_fault_out;
  endproperty
  a_fetch_grant: assert property (p_fetch_grant) else $error("fetch not granted");
  property p_one_answer;
    access_valid_in && !access_from_debug_in |=> access_grant_out != bus_fault_out;
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("access answer wrong");
  property p_fault_cause;
    bus_fault_out |-> $past(access_valid_in && (!access_fetch_in || access_from_debug_in));
  endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("fault without data read");
  property p_masked_sub;
    (masked_int_status_out == (raw_int_status_out & $past(interrupt_mask_reg_in)))
      && (flash_int_out == (|masked_int_status_out));
  endproperty
  a_masked_sub: assert property (p_masked_sub) else $error("masked flag or interrupt wrong");
  property p_clear;
    masked_status_clear_wr_in && masked_status_clear_reg_in == 2'h3 && !flash_op_done_in &&
      !$past(flash_op_done_in) && !flash_control_wr_in && !$past(flash_control_wr_in) |=> raw_int_status_out == 2'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared");
  property p_commit_time;
    $rose(flash_control_busy_out[3]) |-> flash_control_busy_out[3] [*8] ##1 flash_control_busy_out[3]
      ##1 flash_control_busy_out[3] ##1 !flash_control_busy_out[3];
  endproperty
  a_commit_time: assert property (p_commit_time) else $error("commit busy length wrong");
  property p_clear_only;
    quiet == 3'h7 && $stable(policy_rd_sel_in[1:0]) |=> (read_enable_policy_out & ~$past(read_enable_policy_out)) == 0
      && (program_enable_policy_out & ~$past(program_enable_policy_out)) == 0;
  endproperty
  a_clear_only: assert property (p_clear_only) else $error("policy bit set");
  property p_prog_flag;
    flash_op_done_in && flash_control_busy_out[2:0] != 3'h0 |-> ##[1:2] raw_int_status_out[1];
  endproperty
  a_prog_flag: assert property (p_prog_flag) else $error("completion flag missing");
  property p_factory;
    $fell(reset_in) |-> &read_enable_policy_out && &program_enable_policy_out;
  endproperty
  a_factory: assert property (p_factory) else $error("policy not open after reset");
  c_fault: cover property (access_valid_in && !access_fetch_in ##1 bus_fault_out);
  c_commit: cover property ($rose(flash_control_busy_out[3]));
  c_violation: cover property ($rose(raw_int_status_out[0]));
endmodule
`default_nettype wire

/* bench/flash_engine_model.sv */
// Behavioural flash array engine answering start pulses with a done pulse
`default_nettype none
module flash_engine_model (
  input wire logic clk_in,
  input wire logic start_in,
  input wire logic slow_in,
  output logic done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // **************
  // Array timing
  // **************
  int wait_cnt = 0;
  initial done_out = 1'h0;
  // Slow mode stretches the operation so busy polling is exercised
  always @(negedge clk_in) begin
    done_out <= 1'h0;
    if (start_in) wait_cnt = slow_in ? 6 : 1;
    else if (wait_cnt > 1) wait_cnt--;
    else if (wait_cnt == 1) begin
      wait_cnt = 0;
      done_out <= 1'h1;
    end
  end
endmodule
`default_nettype wire

/* bench/flash_block_protection_tb_top.sv */
// Self-checking bench for the flash block protection checker
`default_nettype none
module flash_block_protection_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_in = 1'h0, reset_in = 1'h1, por = 1'h0, valid = 1'h0, fetch = 1'h0, dbg = 1'h0;
  logic wrd = 1'h0, wpg = 1'h0, ctl_wr = 1'h0, clr_wr = 1'h0, slow = 1'h0, started = 1'h0, scan = 1'h0;
  logic [1:0] wsel = '0, mask = '0, clr = '0, kind, raw, msk_st;
  logic [17:0] addr = '0;
  logic [31:0] wdata = '0, rsel = '0, target = '0, ctl = '0, fdata = '1, com0, rd_pol, pg_pol, dbg_word;
  logic grant, fault, done, start, irq, dbg_en;
  logic [3:0] busy;
  logic [31:0] sh_rd [4], sh_pg [4];
  int n_fail = 0, comparisons = 0, cycles = 0;
  flash_block_protection DUT (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .por_in(por),
    .access_valid_in(valid), .access_addr_in(addr), .access_fetch_in(fetch), .access_from_debug_in(dbg),
    .access_is_jtag_scan_in(scan), .access_grant_out(grant), .bus_fault_out(fault),
    .policy_wr_sel_in(wsel), .policy_wr_read_in(wrd), .policy_wr_prog_in(wpg), .policy_wr_data_in(wdata),
    .policy_rd_sel_in(rsel), .read_enable_policy_out(rd_pol), .program_enable_policy_out(pg_pol),
    .target_address_reg_in(target), .flash_data_in(fdata), .flash_control_wr_in(ctl_wr),
    .flash_control_reg_in(ctl), .flash_control_busy_out(busy), .flash_op_done_in(done),
    .flash_op_start_out(start), .flash_op_kind_out(kind), .interrupt_mask_reg_in(mask),
    .masked_status_clear_wr_in(clr_wr), .masked_status_clear_reg_in(clr), .raw_int_status_out(raw),
    .masked_int_status_out(msk_st), .flash_int_out(irq), .debug_enabled_out(dbg_en), .debug_lock_word_out(dbg_word));
  flash_engine_model engine (.clk_in(ref_clk_in), .start_in(start), .slow_in(slow), .done_out(done));
  // ****************
  // Clock and tasks
  // ****************
  always #5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) if (start) started <= 1'h1;
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  function automatic logic [1:0] exp_acc(logic [17:0] a, logic f);
    return (f || sh_rd[a[17:16]][a[15:11]]) ? 2'h2 : 2'h1;
  endfunction
  task automatic read_bank(int b);
    rsel = 32'(b);
    tick(1);
    check("read policy", rd_pol, sh_rd[b]);
    check("program policy", pg_pol, sh_pg[b]);
  endtask
  task automatic wpol(int b, logic is_rd, logic [31:0] d);
    wsel = 2'(b);
    wdata = d;
    wrd = is_rd;
    wpg = !is_rd;
    tick(1);
    wrd = 1'h0;
    wpg = 1'h0;
    tick(1);
    if (is_rd) sh_rd[b] &= d;
    else sh_pg[b] &= d;
  endtask
  task automatic run_acc(int n);
    logic [17:0] a;
    for (int i = 0; i < n; i++) begin
      a = (i == 0) ? 18'h0 : (i == 1) ? 18'h3ffff : 18'($urandom);
      addr = a;
      fetch = 1'($urandom);
      dbg = 1'($urandom);
      valid = 1'h1;
      tick(1);
      check("grant and fault", {grant, fault}, exp_acc(a, fetch));
    end
    valid = 1'h0;
  endtask
  task automatic ctl_op(logic [31:0] c, logic [31:0] t);
    started = 1'h0;
    target = t;
    ctl = c;
    ctl_wr = 1'h1;
    tick(1);
    ctl_wr = 1'h0;
    tick(2);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 50 && busy !== 4'h0; i++) tick(1);
    check("busy", busy, 4'h0);
    tick(1);
  endtask
  task automatic por_pulse();
    por = 1'h1;
    tick(4);
    por = 1'h0;
    tick(6);
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    void'($urandom(32'h7c1e8748));
    for (int b = 0; b < 4; b++) begin
      sh_rd[b] = '1;
      sh_pg[b] = '1;
    end
    tick(4);
    reset_in = 1'h0;
    for (int b = 0; b < 4; b++) read_bank(b);
    check("debug enable", dbg_en, 1'h1);
    for (int i = 0; i < 8; i++) wpol(i % 4, 1'h1, $urandom | $urandom);
    wpol(1, 1'h1, '1);
    for (int b = 0; b < 4; b++) read_bank(b);
    run_acc(60);
    wpol(2, 1'h0, 32'hfffffffe);
    // Write and erase, each to an open and a guarded block; writes under mask 1, erases under mask 2
    for (int k = 0; k < 4; k++) begin
      mask = (k < 2) ? 2'h1 : 2'h2;
      slow = k[1];
      ctl_op({16'ha442, 14'h0, k[1], !k[1]}, k[0] ? 32'h20000 : 32'h0);
      wait_idle();
      check("op started", started, !k[0]);
      check("raw status", raw, k[0] ? 2'h1 : 2'h2);
      check("interrupt", irq, mask[!k[0]]);
      clr = 2'h3;
      clr_wr = 1'h1;
      tick(1);
      clr_wr = 1'h0;
      tick(2);
      check("cleared status", {raw, msk_st, irq}, 5'h0);
    end
    ctl_op(32'ha4420008, 32'h0);
    check("commit busy", busy, 4'h8);
    wait_idle();
    com0 = sh_rd[0];
    wpol(0, 1'h1, 32'h7fffffff);
    por_pulse();
    for (int b = 0; b < 4; b++) begin
      sh_rd[b] = (b == 0) ? com0 : '1;
      sh_pg[b] = '1;
      read_bank(b);
    end
    run_acc(30);
    fdata = 32'hfffffffc;
    ctl_op(32'ha4420008, 32'h75100000);
    wait_idle();
    check("debug before restore", dbg_en, 1'h1);
    por_pulse();
    check("debug word", dbg_word, 32'hfffffffc);
    check("debug enable", dbg_en, 1'h0);
    dbg = 1'h1;
    fetch = 1'h0;
    valid = 1'h1;
    tick(1);
    check("debug grant", grant, 1'h0);
    check("debug fault", fault, 1'h1);
    scan = 1'h1;
    tick(1);
    valid = 1'h0;
    scan = 1'h0;
    check("scan answer", {grant, fault}, exp_acc(addr, fetch));
    fdata = 32'hfffffffe;
    ctl_op(32'ha4420008, 32'h75100000);
    wait_idle();
    por_pulse();
    check("debug relock", dbg_en, 1'h0);
    give_verdict();
  end
endmodule
bind flash_block_protection flash_block_protection_chk u_chk (.ref_clk_in, .reset_in, .por_in, .access_valid_in,
  .access_fetch_in, .access_from_debug_in, .access_grant_out, .bus_fault_out, .policy_rd_sel_in,
  .read_enable_policy_out, .program_enable_policy_out, .flash_control_wr_in, .flash_control_busy_out,
  .flash_op_done_in, .masked_status_clear_wr_in, .masked_status_clear_reg_in, .raw_int_status_out,
  .masked_int_status_out, .interrupt_mask_reg_in, .flash_int_out);
`default_nettype wire
